// ### shared/afmc_pkg.sv
/*
  afmc_pkg: register offsets, field positions and reset values for the
  feature mode control block.
  Assumes a 4-bit register address and 16-bit register data.
*/
package afmc_pkg;
  localparam logic [3:0] ADDR_MAIN = 4'h0;
  localparam logic [3:0] ADDR_OFFSET_A = 4'h2;
  localparam logic [3:0] ADDR_RANGE_A = 4'h3;
  localparam logic [3:0] ADDR_CAL_ADJ = 4'h4;
  localparam logic [3:0] ADDR_SKEW = 4'h7;
  localparam logic [3:0] ADDR_OFFSET_B = 4'ha;
  localparam logic [3:0] ADDR_RANGE_B = 4'hb;
  localparam logic [3:0] ADDR_PHASE_A = 4'hc;
  localparam logic [3:0] ADDR_PHASE_B = 4'hd;
  localparam logic [3:0] ADDR_EXT_CLK = 4'he;
  // main configuration fields, then the trim access (cal adjust) and inverted clock (ext clock) bits
  localparam int BIT_CAL = 15;
  localparam int BIT_PHASE = 14;
  localparam int BIT_SWING = 13;
  localparam int BIT_TEST = 12;
  localparam int BIT_PD_I = 11;
  localparam int BIT_PD_Q = 10;
  localparam int BIT_INTERLEAVE = 7;
  localparam int BIT_TWOS = 4;
  localparam int BIT_TSTAMP = 3;
  localparam int BIT_SDR = 2;
  localparam int BIT_TRIM_ACCESS = 7;
  localparam int BIT_INV_CLK = 6;
  // offset register: sign above a 12-bit magnitude
  localparam int OFFSET_SIGN = 12;
  localparam int RANGE_BITS = 15;
  // reset values; swing bit high means higher swing
  localparam logic [15:0] RST_MAIN = 16'h2000;
  localparam logic [15:0] RST_OFFSET = 16'h0000;
  localparam logic [15:0] RST_RANGE = 16'h0000;
  localparam logic [15:0] RST_CAL_ADJ = 16'h0000;
  localparam logic [15:0] RST_SKEW = 16'h0040;
  localparam logic [15:0] RST_PHASE = 16'h0000;
  localparam logic [15:0] RST_EXT_CLK = 16'h0000;
endpackage : afmc_pkg

// ### testbench/testbench.sv
/*
  testbench: self-checking bench for afmc_ctrl, covering register and pin
  control, defaults, read-back and live pins.
  Assumes afmc_pkg compiled first; inputs change 5 ns after MCLK rises.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import afmc_pkg::*;
  logic mclk, rst_b, ecp_n, wr, ilv_p, ph_p, tp_p, cal_p, pdi_p, pdq_p;
  logic [3:0] addr;
  logic [15:0] wdata;
  wire logic [15:0] rdata, skew, ph_i, ph_q;
  wire logic [14:0] rng_i, rng_q;
  wire logic [12:0] off_i, off_q;
  wire logic extended_control_mode, f0, f1, f2, f3, f4, f5, f6, f7, f8, f9, f10, f11;
  wire logic [11:0] flags = {f0, f1, f2, f3, f4, f5, f6, f7, f8, f9, f10, f11};
  int fail_count = 0;
  int num_checks = 0;

  afmc_ctrl dut_u (.MCLK(mclk), .RST_B(rst_b), .EXTENDED_CONTROL_PIN_N(ecp_n),
    .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .INTERLEAVE_PIN(ilv_p), .OUTPUT_PHASE_PIN(ph_p), .TEST_PATTERN_PIN(tp_p),
    .CAL_PIN(cal_p), .I_PD_PIN(pdi_p), .Q_PD_PIN(pdq_p),
    .INPUT_RANGE_PIN(1'b1), .EXTENDED_CONTROL_MODE(extended_control_mode), .INTERLEAVE(f0),
    .OUTPUT_CLOCK_PHASE_SELECT(f1), .SDR_MODE(f2), .OUTPUT_SWING_SELECT(f3),
    .TWOS_COMPLEMENT_SELECT(f4), .TEST_PATTERN_SELECT(f5),
    .TIMESTAMP_ENABLE(f6), .CAL_REQUEST(f7), .I_CHANNEL_POWERDOWN(f8),
    .Q_CHANNEL_POWERDOWN(f9), .TRIM_VALUE_ACCESS_ENABLE(f10),
    .INVERTED_CLOCK_INPUT_SELECT(f11), .SKEW_ADJUST(skew), .RANGE_I(rng_i),
    .RANGE_Q(rng_q), .OFFSET_I(off_i), .OFFSET_Q(off_q),
    .PHASE_ADJ_I(ph_i), .PHASE_ADJ_Q(ph_q));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  function automatic logic [15:0] fl(logic [15:0] m, logic [15:0] c,
                                     logic [15:0] e);
    return {4'h0, m[BIT_INTERLEAVE], m[BIT_PHASE], m[BIT_SDR], m[BIT_SWING],
            m[BIT_TWOS], m[BIT_TEST], m[BIT_TSTAMP], m[BIT_CAL], m[BIT_PD_I],
            m[BIT_PD_Q], c[BIT_TRIM_ACCESS], e[BIT_INV_CLK]};
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n = 1);
    repeat (n) @(posedge mclk);
    #5;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    step();
    wr = 1'b0;
    step();
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    addr = a;
    step(2);
    chk(rdata, exp);
  endtask

  task automatic t_defaults();
    step(2);
    chk({15'h0, extended_control_mode}, 16'h0001);
    chk({4'h0, flags}, fl(RST_MAIN, 16'h0, 16'h0));
    chk({11'h0, f3, f4, f5, f6, f7}, 16'h0010);
    chk(skew, 16'h0040);
    chk({1'b0, rng_i | rng_q}, 16'h0000);
    chk({3'h0, off_i | off_q}, 16'h0000);
    chk(ph_i | ph_q, 16'h0000);
    rd_chk(ADDR_MAIN, 16'h2000);
    rd_chk(ADDR_SKEW, 16'h0040);
    rd_chk(ADDR_CAL_ADJ, 16'h0000);
  endtask

  task automatic t_main_bits();
    // pattern pins held high: they must not leak through in register mode
    ilv_p = 1'b1;
    ph_p = 1'b1;
    tp_p = 1'b1;
    for (int b = 0; b < 16; b++) begin
      wr_reg(ADDR_MAIN, 16'h0001 << b);
      step();
      chk(flags, fl(16'h0001 << b, 16'h0, 16'h0));
      rd_chk(ADDR_MAIN, 16'h0001 << b);
    end
    wr_reg(ADDR_MAIN, 16'hffff);
    wr_reg(ADDR_MAIN, 16'h0000);
    step();
    chk(flags, 16'h0);
  endtask

  task automatic t_live_pins();
    cal_p = 1'b1;
    pdi_p = 1'b1;
    pdq_p = 1'b1;
    step(2);
    chk(flags, 16'h0007 << 2);
    cal_p = 1'b0;
    pdi_p = 1'b0;
    pdq_p = 1'b0;
    step(2);
    chk(flags, 16'h0);
  endtask

  task automatic t_data_regs();
    wr_reg(ADDR_RANGE_A, 16'hffff);
    wr_reg(ADDR_RANGE_B, 16'h0001);
    wr_reg(ADDR_OFFSET_A, 16'h1fff);
    wr_reg(ADDR_OFFSET_B, 16'h1001);
    wr_reg(ADDR_SKEW, 16'h007f);
    wr_reg(ADDR_PHASE_A, 16'h1234);
    wr_reg(ADDR_PHASE_B, 16'h8765);
    wr_reg(ADDR_CAL_ADJ, 16'h0080);
    wr_reg(ADDR_EXT_CLK, 16'h0040);
    wr_reg(4'h5, 16'hbeef);
    // range changed: host calibrates before relying on it
    cal_p = 1'b1;
    step(2);
    chk({15'h0, f7}, 16'h0001);
    cal_p = 1'b0;
    step();
    step();
    chk({1'b0, rng_i}, 16'h7fff);
    chk({1'b0, rng_q}, 16'h0001);
    chk({3'h0, off_i}, 16'h1fff);
    chk({3'h0, off_q}, 16'h1001);
    chk(skew, 16'h007f);
    chk(ph_i, 16'h1234);
    chk(ph_q, 16'h8765);
    chk(flags, fl(16'h0, 16'h0080, 16'h0040));
    rd_chk(ADDR_RANGE_A, 16'hffff);
    rd_chk(4'h5, 16'h0000);
    rd_chk(4'h1, 16'h0000);
  endtask

  task automatic t_pin_mode();
    ecp_n = 1'b1;
    ilv_p = 1'b1;
    ph_p = 1'b0;
    tp_p = 1'b1;
    wr_reg(ADDR_MAIN, 16'h0000);
    step(2);
    chk({15'h0, extended_control_mode}, 16'h0);
    chk(flags, 16'h0940);
    chk({1'b0, rng_i}, 16'h0);
    chk(skew, RST_SKEW);
    rd_chk(ADDR_SKEW, 16'h0000);
    ilv_p = 1'b0;
    ph_p = 1'b1;
    step(2);
    chk(flags, 16'h0540);
    // releasing pin control must reveal defaults, not the refused write
    ecp_n = 1'b0;
    step(2);
    rd_chk(ADDR_MAIN, RST_MAIN);
    rd_chk(ADDR_RANGE_A, 16'h0);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #100000;
    fail_count++;
    close_out();
  end

  initial begin
    {rst_b, ecp_n, wr, ilv_p, ph_p, tp_p, cal_p, pdi_p, pdq_p} = '0;
    addr = 4'h0;
    wdata = 16'h0000;
    step(16);
    rst_b = 1'b1;
    t_defaults();
    t_main_bits();
    t_live_pins();
    t_data_regs();
    t_pin_mode();
    close_out();
  end
endmodule // testbench
`default_nettype wire

// ### verilog/afmc_ctrl.sv
/*
  afmc_ctrl: feature mode selection between control pins and the
  configuration registers of a dual-channel sampling converter.
  Assumes a register port (address, write strobe, data) synchronous to
  MCLK, decoded by a serial front end outside this block.
*/
`timescale 1ns/100ps
`default_nettype none
module afmc_ctrl
  import afmc_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic EXTENDED_CONTROL_PIN_N,
  input wire logic [3:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [15:0] REG_WDATA,
  output logic [15:0] REG_RDATA,
  input wire logic INTERLEAVE_PIN,
  input wire logic OUTPUT_PHASE_PIN,
  input wire logic TEST_PATTERN_PIN,
  input wire logic CAL_PIN,
  input wire logic I_PD_PIN,
  input wire logic Q_PD_PIN,
  input wire logic INPUT_RANGE_PIN,
  output logic EXTENDED_CONTROL_MODE,
  output logic INTERLEAVE,
  output logic OUTPUT_CLOCK_PHASE_SELECT,
  output logic SDR_MODE,
  output logic OUTPUT_SWING_SELECT,
  output logic TWOS_COMPLEMENT_SELECT,
  output logic TEST_PATTERN_SELECT,
  output logic TIMESTAMP_ENABLE,
  output logic CAL_REQUEST,
  output logic I_CHANNEL_POWERDOWN,
  output logic Q_CHANNEL_POWERDOWN,
  output logic TRIM_VALUE_ACCESS_ENABLE,
  output logic INVERTED_CLOCK_INPUT_SELECT,
  output logic [15:0] SKEW_ADJUST,
  output logic [RANGE_BITS-1:0] RANGE_I,
  output logic [RANGE_BITS-1:0] RANGE_Q,
  output logic [OFFSET_SIGN:0] OFFSET_I,
  output logic [OFFSET_SIGN:0] OFFSET_Q,
  output logic [15:0] PHASE_ADJ_I,
  output logic [15:0] PHASE_ADJ_Q
);
  logic [15:0] main_cfg, off_a, off_b, rng_a, rng_b, cal_adj, skew;
  logic [15:0] ph_a, ph_b, ext_clk;
  wire extended_control_mode = ~EXTENDED_CONTROL_PIN_N;
  wire wr_ok = REG_WR & extended_control_mode;
  wire [15:0] rd_mux =
    (REG_ADDR == ADDR_MAIN) ? main_cfg :
    (REG_ADDR == ADDR_OFFSET_A) ? off_a :
    (REG_ADDR == ADDR_RANGE_A) ? rng_a :
    (REG_ADDR == ADDR_CAL_ADJ) ? cal_adj :
    (REG_ADDR == ADDR_SKEW) ? skew :
    (REG_ADDR == ADDR_OFFSET_B) ? off_b :
    (REG_ADDR == ADDR_RANGE_B) ? rng_b :
    (REG_ADDR == ADDR_PHASE_A) ? ph_a :
    (REG_ADDR == ADDR_PHASE_B) ? ph_b :
    (REG_ADDR == ADDR_EXT_CLK) ? ext_clk : 16'h0000;

  // registers fall back to defaults whenever pin control is in force
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      main_cfg <= RST_MAIN;
      off_a <= RST_OFFSET;
      off_b <= RST_OFFSET;
      rng_a <= RST_RANGE;
      rng_b <= RST_RANGE;
      cal_adj <= RST_CAL_ADJ;
      skew <= RST_SKEW;
      ph_a <= RST_PHASE;
      ph_b <= RST_PHASE;
      ext_clk <= RST_EXT_CLK;
    end else if (!extended_control_mode) begin
      main_cfg <= RST_MAIN;
      off_a <= RST_OFFSET;
      off_b <= RST_OFFSET;
      rng_a <= RST_RANGE;
      rng_b <= RST_RANGE;
      cal_adj <= RST_CAL_ADJ;
      skew <= RST_SKEW;
      ph_a <= RST_PHASE;
      ph_b <= RST_PHASE;
      ext_clk <= RST_EXT_CLK;
    end else if (wr_ok) begin
      if (REG_ADDR == ADDR_MAIN) main_cfg <= REG_WDATA;
      if (REG_ADDR == ADDR_OFFSET_A) off_a <= REG_WDATA;
      if (REG_ADDR == ADDR_OFFSET_B) off_b <= REG_WDATA;
      if (REG_ADDR == ADDR_RANGE_A) rng_a <= REG_WDATA;
      if (REG_ADDR == ADDR_RANGE_B) rng_b <= REG_WDATA;
      if (REG_ADDR == ADDR_CAL_ADJ) cal_adj <= REG_WDATA;
      if (REG_ADDR == ADDR_SKEW) skew <= REG_WDATA;
      if (REG_ADDR == ADDR_PHASE_A) ph_a <= REG_WDATA;
      if (REG_ADDR == ADDR_PHASE_B) ph_b <= REG_WDATA;
      if (REG_ADDR == ADDR_EXT_CLK) ext_clk <= REG_WDATA;
    end
  end

  // effective settings: pin or fixed value under pin control, register otherwise; cal and power-down pins ORed in both modes
  wire next_ilv = extended_control_mode ? main_cfg[BIT_INTERLEAVE] : INTERLEAVE_PIN;
  wire next_ph = extended_control_mode ? main_cfg[BIT_PHASE] : OUTPUT_PHASE_PIN;
  wire next_sdr = extended_control_mode & main_cfg[BIT_SDR];
  wire next_swing = extended_control_mode ? main_cfg[BIT_SWING] : 1'b1;
  wire next_twos = extended_control_mode & main_cfg[BIT_TWOS];
  wire next_tp = extended_control_mode ? main_cfg[BIT_TEST] : TEST_PATTERN_PIN;
  wire next_ts = extended_control_mode & main_cfg[BIT_TSTAMP];
  wire next_cal = CAL_PIN | (extended_control_mode & main_cfg[BIT_CAL]);
  wire next_pdi = I_PD_PIN | (extended_control_mode & main_cfg[BIT_PD_I]);
  wire next_pdq = Q_PD_PIN | (extended_control_mode & main_cfg[BIT_PD_Q]);
  wire next_trim = extended_control_mode & cal_adj[BIT_TRIM_ACCESS];
  wire next_inv = extended_control_mode & ext_clk[BIT_INV_CLK];
  // pin control only offers the high pin level, mapped to lowest range
  wire [RANGE_BITS-1:0] next_rng_a = extended_control_mode ? rng_a[RANGE_BITS-1:0] :
    RST_RANGE[RANGE_BITS-1:0];
  wire [RANGE_BITS-1:0] next_rng_b = extended_control_mode ? rng_b[RANGE_BITS-1:0] :
    RST_RANGE[RANGE_BITS-1:0];

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      EXTENDED_CONTROL_MODE <= 1'b0;
      INTERLEAVE <= 1'b0;
      OUTPUT_CLOCK_PHASE_SELECT <= 1'b0;
      SDR_MODE <= 1'b0;
      OUTPUT_SWING_SELECT <= 1'b1;
      TWOS_COMPLEMENT_SELECT <= 1'b0;
      TEST_PATTERN_SELECT <= 1'b0;
      TIMESTAMP_ENABLE <= 1'b0;
      CAL_REQUEST <= 1'b0;
      I_CHANNEL_POWERDOWN <= 1'b0;
      Q_CHANNEL_POWERDOWN <= 1'b0;
      TRIM_VALUE_ACCESS_ENABLE <= 1'b0;
      INVERTED_CLOCK_INPUT_SELECT <= 1'b0;
      SKEW_ADJUST <= RST_SKEW;
      RANGE_I <= RST_RANGE[RANGE_BITS-1:0];
      RANGE_Q <= RST_RANGE[RANGE_BITS-1:0];
      OFFSET_I <= RST_OFFSET[OFFSET_SIGN:0];
      OFFSET_Q <= RST_OFFSET[OFFSET_SIGN:0];
      PHASE_ADJ_I <= RST_PHASE;
      PHASE_ADJ_Q <= RST_PHASE;
      REG_RDATA <= 16'h0000;
    end else begin
      EXTENDED_CONTROL_MODE <= extended_control_mode;
      INTERLEAVE <= next_ilv;
      OUTPUT_CLOCK_PHASE_SELECT <= next_ph;
      SDR_MODE <= next_sdr;
      OUTPUT_SWING_SELECT <= next_swing;
      TWOS_COMPLEMENT_SELECT <= next_twos;
      TEST_PATTERN_SELECT <= next_tp;
      TIMESTAMP_ENABLE <= next_ts;
      CAL_REQUEST <= next_cal;
      I_CHANNEL_POWERDOWN <= next_pdi;
      Q_CHANNEL_POWERDOWN <= next_pdq;
      TRIM_VALUE_ACCESS_ENABLE <= next_trim;
      INVERTED_CLOCK_INPUT_SELECT <= next_inv;
      SKEW_ADJUST <= extended_control_mode ? skew : RST_SKEW;
      RANGE_I <= next_rng_a;
      RANGE_Q <= next_rng_b;
      OFFSET_I <= extended_control_mode ? off_a[OFFSET_SIGN:0] : RST_OFFSET[OFFSET_SIGN:0];
      OFFSET_Q <= extended_control_mode ? off_b[OFFSET_SIGN:0] : RST_OFFSET[OFFSET_SIGN:0];
      PHASE_ADJ_I <= extended_control_mode ? ph_a : RST_PHASE;
      PHASE_ADJ_Q <= extended_control_mode ? ph_b : RST_PHASE;
      REG_RDATA <= extended_control_mode ? rd_mux : 16'h0000;
    end
  end

  property p_defaults_in_pin_mode;
    @(posedge MCLK) disable iff (!RST_B)
      EXTENDED_CONTROL_PIN_N |=> main_cfg == RST_MAIN && skew == RST_SKEW;
  endproperty
  a_defaults_in_pin_mode: assert property (p_defaults_in_pin_mode)
    else $error("registers not at defaults under pin control");

  sequence s_main_write;
    extended_control_mode && REG_WR && REG_ADDR == ADDR_MAIN;
  endsequence
  property p_interleave_reg;
    @(posedge MCLK) disable iff (!RST_B)
      s_main_write ##1 extended_control_mode |=> INTERLEAVE ==
        $past(REG_WDATA[BIT_INTERLEAVE], 2);
  endproperty
  a_interleave_reg: assert property (p_interleave_reg)
    else $error("interleave does not follow register");

  property p_phase_pin;
    @(posedge MCLK) disable iff (!RST_B)
      !extended_control_mode |=> OUTPUT_CLOCK_PHASE_SELECT == $past(OUTPUT_PHASE_PIN);
  endproperty
  a_phase_pin: assert property (p_phase_pin)
    else $error("phase does not follow pin");

  property p_pin_mode_fixed;
    @(posedge MCLK) disable iff (!RST_B)
      !extended_control_mode |=> !SDR_MODE && OUTPUT_SWING_SELECT && !TWOS_COMPLEMENT_SELECT
        && !TIMESTAMP_ENABLE;
  endproperty
  a_pin_mode_fixed: assert property (p_pin_mode_fixed)
    else $error("pin mode fixed settings wrong");

  property p_test_pin;
    @(posedge MCLK) disable iff (!RST_B)
      !extended_control_mode |=> TEST_PATTERN_SELECT == $past(TEST_PATTERN_PIN);
  endproperty
  a_test_pin: assert property (p_test_pin)
    else $error("test pattern does not follow pin");

  property p_cal_pin;
    @(posedge MCLK) disable iff (!RST_B)
      CAL_PIN |=> CAL_REQUEST;
  endproperty
  a_cal_pin: assert property (p_cal_pin)
    else $error("calibration pin ignored");

  property p_pd_pins;
    @(posedge MCLK) disable iff (!RST_B)
      (I_PD_PIN && Q_PD_PIN) |=> I_CHANNEL_POWERDOWN && Q_CHANNEL_POWERDOWN;
  endproperty
  a_pd_pins: assert property (p_pd_pins)
    else $error("power-down pin ignored");

  property p_range_pin_mode;
    @(posedge MCLK) disable iff (!RST_B)
      !extended_control_mode |=> RANGE_I == 15'h0000 && RANGE_Q == 15'h0000;
  endproperty
  a_range_pin_mode: assert property (p_range_pin_mode)
    else $error("range not lowest under pin control");

  property p_sdr_reg;
    @(posedge MCLK) disable iff (!RST_B)
      extended_control_mode |=> SDR_MODE == $past(main_cfg[BIT_SDR]);
  endproperty
  a_sdr_reg: assert property (p_sdr_reg)
    else $error("single rate does not follow register");

  property p_swing_reg;
    @(posedge MCLK) disable iff (!RST_B)
      s_main_write ##1 extended_control_mode |=> OUTPUT_SWING_SELECT ==
        $past(REG_WDATA[BIT_SWING], 2);
  endproperty
  a_swing_reg: assert property (p_swing_reg)
    else $error("swing does not follow register");

  property p_twos_reg;
    @(posedge MCLK) disable iff (!RST_B)
      extended_control_mode |=> TWOS_COMPLEMENT_SELECT == $past(main_cfg[BIT_TWOS]);
  endproperty
  a_twos_reg: assert property (p_twos_reg)
    else $error("number format does not follow register");

  property p_test_reg;
    @(posedge MCLK) disable iff (!RST_B)
      extended_control_mode |=> TEST_PATTERN_SELECT == $past(main_cfg[BIT_TEST]);
  endproperty
  a_test_reg: assert property (p_test_reg)
    else $error("test pattern does not follow register");

  property p_tstamp_reg;
    @(posedge MCLK) disable iff (!RST_B)
      extended_control_mode |=> TIMESTAMP_ENABLE == $past(main_cfg[BIT_TSTAMP]);
  endproperty
  a_tstamp_reg: assert property (p_tstamp_reg)
    else $error("time stamp does not follow register");

  property p_pd_i_reg;
    @(posedge MCLK) disable iff (!RST_B)
      extended_control_mode |=> I_CHANNEL_POWERDOWN ==
        ($past(I_PD_PIN) || $past(main_cfg[BIT_PD_I]));
  endproperty
  a_pd_i_reg: assert property (p_pd_i_reg)
    else $error("I power-down not pin or register");

  property p_pd_q_reg;
    @(posedge MCLK) disable iff (!RST_B)
      extended_control_mode |=> Q_CHANNEL_POWERDOWN ==
        ($past(Q_PD_PIN) || $past(main_cfg[BIT_PD_Q]));
  endproperty
  a_pd_q_reg: assert property (p_pd_q_reg)
    else $error("Q power-down not pin or register");

  property p_trim_reg;
    @(posedge MCLK) disable iff (!RST_B)
      extended_control_mode |=> TRIM_VALUE_ACCESS_ENABLE == $past(cal_adj[BIT_TRIM_ACCESS]);
  endproperty
  a_trim_reg: assert property (p_trim_reg)
    else $error("trim access does not follow register");

  property p_inv_clk_pin_mode;
    @(posedge MCLK) disable iff (!RST_B)
      !extended_control_mode |=> !INVERTED_CLOCK_INPUT_SELECT;
  endproperty
  a_inv_clk_pin_mode: assert property (p_inv_clk_pin_mode)
    else $error("inverted clock input set under pin control");

  property p_skew_pin_mode;
    @(posedge MCLK) disable iff (!RST_B)
      !extended_control_mode |=> SKEW_ADJUST == RST_SKEW;
  endproperty
  a_skew_pin_mode: assert property (p_skew_pin_mode)
    else $error("skew not at mid value under pin control");
endmodule : afmc_ctrl
`default_nettype wire
